//--- hw/flash_page_program_ecc.sv
// Page program sequencer with per-unit automatic error correction.
// Assumes a serial host on cs_n_i, sck_i, io_i and a classic Wishbone
// master for configuration, erase and corrected read-back.
//
// What this block does
// - Keep one check code per aligned 16-byte unit.
// - A second program to a unit disables its correction.
// - Each unit holds 8 check bits plus a programmed flag and a disable flag.
// - Sector erase restores check bits and flags to enabled default.
// - Disabled units read back raw, uncorrected.
// - Enabled units have single-bit errors fixed on read.
// - Correction covers the whole array, one-time region included.
// - One-time region units never re-enable; erase skips them.
// - Page is 512 or 1024 bytes, aligned to its size.
// - One program takes from one byte (two bytes for wide) up to a full page.
// - Non-wide program (data on lines 0 and 4) needs write enable decoded and latch set.
// - 02h uses 3 or 4 address bytes by flag; 12h always 4.
// - Data past page end wraps to the page start.
// - Only sent bytes change; other page bytes stay untouched.
// - Busy bit 0 of status one is high while programming.
// - Program error bit 6 sets when programming cannot complete.
// - 32h and 38h follow the flag; 34h always 4 address bytes.
// - Wide program loads a byte per clock on all eight lines.
// - Wide program needs the wide-I/O enable bit set.
// - Wide program needs the write enable latch set.
// - Wide program marks every unit of the page programmed.
`timescale 1ns/1ps
`include "flash_page_program_ecc_defines.svh"

module flash_page_program_ecc
	import flash_page_program_ecc_pkg::*;
#(
	parameter int ARRAY_BYTES  = 4096,
	parameter int OTP_BASE     = 3072,
	parameter int SECTOR_BYTES = 1024,
	parameter int MAX_PAGE     = `PAGE_LARGE
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cs_n_i,
	input  wire logic        sck_i,
	input  wire logic [7:0]  io_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o
);

	localparam int AW    = $clog2(ARRAY_BYTES);
	localparam int UNITS = ARRAY_BYTES / `UNIT_BYTES;
	localparam int PW    = $clog2(MAX_PAGE);
	localparam int IW    = PW - 4;
	localparam logic [3:0] PROG_WAIT = 4'(`PROG_UNIT_CYCLES - 1);

	// Hamming code over 128 data bits; positions skip powers of two.
	function automatic logic [7:0] ecc_code(input logic [127:0] d);
		logic [7:0] c;
		int         k;
		c = 8'h00;
		k = 0;
		for (int p = 3; p < 256; p++) begin
			if (((p & (p - 1)) != 0) && (k < 128)) begin
				if (d[k])
					c = c ^ p[7:0];
				k = k + 1;
			end
		end
		return c;
	endfunction

	// Flips the one data bit that the syndrome points at.
	function automatic logic [127:0] ecc_fix(input logic [127:0] d,
		input logic [7:0] syn);
		logic [127:0] r;
		int           k;
		r = d;
		k = 0;
		for (int p = 3; p < 256; p++) begin
			if (((p & (p - 1)) != 0) && (k < 128)) begin
				if (syn == p[7:0])
					r[k] = ~r[k];
				k = k + 1;
			end
		end
		return r;
	endfunction

	// Byte-lane merge for bus writes.
	function automatic logic [31:0] lane_merge(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i])
				r[8*i +: 8] = dat[8*i +: 8];
		end
		return r;
	endfunction

	function automatic logic is_wide_op(input logic [7:0] op);
		return (op == `OP_WIDE) || (op == `OP_WIDE_ALT) ||
			(op == `OP_WIDE_ADDR32);
	endfunction

	// Pin synchronisers and edge detection.
	logic       cs_s1, cs_s2, cs_s3;
	logic       sck_s1, sck_s2, sck_s3;
	logic [7:0] io_s1, io_s2;
	logic       sck_rise, cs_fall, cs_rise;

	// Serial front end.
	spi_state_type   spi_state_reg;
	logic [31:0]     shift_reg;
	logic [5:0]      bit_cnt_reg;
	logic [5:0]      addr_len_reg;
	logic            is_wide_reg;
	logic [1:0]      sub_reg;
	logic [5:0]      data_sh_reg;
	logic [1:0]      got_reg;
	logic [PW-1:0]   col_reg;
	logic [31:0]     page_base_reg;
	logic [7:0]      page_buf [MAX_PAGE];
	logic [MAX_PAGE-1:0] loaded_reg;
	logic            commit_reg;
	logic            latch_set_reg;
	logic [7:0]      opcode_next;
	logic [31:0]     addr_next;
	logic [31:0]     addr_full;
	logic [PW-1:0]   page_mask;

	// Array, engine and status.
	logic [7:0]      mem [ARRAY_BYTES];
	unit_meta_type   meta [UNITS];
	prog_state_type  prog_state_reg;
	logic [IW-1:0]   unit_idx_reg;
	logic [3:0]      wait_cnt_reg;
	logic            write_in_progress_reg;
	logic            write_enable_latch_reg;
	logic            program_error_reg;
	logic [AW-1:0]   ubase;
	logic [127:0]    unit_new;
	logic            unit_touched;

	// Bus side.
	config_type      cfg_reg;
	logic            ack_reg;
	logic [31:0]     dat_reg;
	logic [AW-1:0]   rd_addr_reg;
	logic            erase_req_reg;
	logic [7:0]      erase_sector_reg;
	logic            error_clr_reg;
	logic [31:0]     rd_word;
	logic [127:0]    rd_raw;
	logic [127:0]    rd_fixed;
	logic [7:0]      rd_syn;
	unit_meta_type   rd_meta;
	logic            rd_enabled;
	logic [31:0]     cfg_merged;
	logic [31:0]     rd_addr_merged;

	assign ack_o = ack_reg;
	assign dat_o = dat_reg;

	// Lane merges for register writes; only the low bits are kept.
	assign cfg_merged     = lane_merge({29'h0, cfg_reg}, dat_i, sel_i);
	assign rd_addr_merged = lane_merge(32'(rd_addr_reg), dat_i, sel_i);

	// Pins pass two flops before any logic looks at them.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			cs_s3 <= 1'b1;
			sck_s1 <= 1'b0;
			sck_s2 <= 1'b0;
			sck_s3 <= 1'b0;
			io_s1 <= 8'h00;
			io_s2 <= 8'h00;
		end else begin
			cs_s1 <= cs_n_i;
			cs_s2 <= cs_s1;
			cs_s3 <= cs_s2;
			sck_s1 <= sck_i;
			sck_s2 <= sck_s1;
			sck_s3 <= sck_s2;
			io_s1 <= io_i;
			io_s2 <= io_s1;
		end
	end

	assign sck_rise = sck_s2 & ~sck_s3;
	assign cs_fall  = ~cs_s2 & cs_s3;
	assign cs_rise  = cs_s2 & ~cs_s3;

	// Opcode, address width and page wrap mask.
	assign opcode_next = {shift_reg[6:0], io_s2[0]};
	assign addr_next   = {shift_reg[30:0], io_s2[0]};
	assign addr_full   = (addr_len_reg == 6'd32) ? addr_next :
		{8'h00, addr_next[23:0]};
	assign page_mask   = cfg_reg.page_large ? PW'(`PAGE_LARGE - 1) :
		PW'(`PAGE_SMALL - 1);

	// Serial command decoder and page buffer loader.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			spi_state_reg <= S_IDLE;
			shift_reg <= 32'h0000_0000;
			bit_cnt_reg <= 6'h00;
			addr_len_reg <= 6'd24;
			is_wide_reg <= 1'b0;
			sub_reg <= 2'h0;
			data_sh_reg <= 6'h00;
			got_reg <= 2'h0;
			col_reg <= '0;
			page_base_reg <= 32'h0000_0000;
			loaded_reg <= '0;
			commit_reg <= 1'b0;
			latch_set_reg <= 1'b0;
		end else begin
			commit_reg <= 1'b0;
			latch_set_reg <= 1'b0;
			if (cs_s2) begin
				// Only a whole byte and enough of them start the array.
				if (cs_rise && spi_state_reg == S_DATA && sub_reg == 2'h0 &&
					got_reg >= (is_wide_reg ? 2'h2 : 2'h1))
					commit_reg <= 1'b1;
				spi_state_reg <= S_IDLE;
			end else if (cs_fall) begin
				spi_state_reg <= S_OPCODE;
				bit_cnt_reg <= 6'h00;
			end else if (sck_rise) begin
				case (spi_state_reg)
				S_OPCODE: begin
					shift_reg <= addr_next;
					bit_cnt_reg <= bit_cnt_reg + 6'h01;
					if (bit_cnt_reg == 6'h07) begin
						spi_state_reg <= S_IGNORE;
						if (opcode_next == `OP_WRITE_ENABLE)
							latch_set_reg <= 1'b1;
						else if ((opcode_next == `OP_PROG ||
							opcode_next == `OP_PROG_ADDR32 ||
							is_wide_op(opcode_next)) &&
							!write_in_progress_reg &&
							write_enable_latch_reg &&
							(!is_wide_op(opcode_next) ||
							cfg_reg.wide_io_enable)) begin
							spi_state_reg <= S_ADDR;
							bit_cnt_reg <= 6'h00;
							is_wide_reg <= is_wide_op(opcode_next);
							loaded_reg <= '0;
							if (opcode_next == `OP_PROG_ADDR32 ||
								opcode_next == `OP_WIDE_ADDR32 ||
								cfg_reg.extended_address_flag)
								addr_len_reg <= 6'd32;
							else
								addr_len_reg <= 6'd24;
						end
					end
				end
				S_ADDR: begin
					shift_reg <= addr_next;
					bit_cnt_reg <= bit_cnt_reg + 6'h01;
					if (bit_cnt_reg == addr_len_reg - 6'h01) begin
						page_base_reg <= addr_full &
							~{{(32-PW){1'b0}}, page_mask};
						col_reg <= addr_full[PW-1:0] & page_mask;
						sub_reg <= 2'h0;
						got_reg <= 2'h0;
						spi_state_reg <= S_DATA;
					end
				end
				S_DATA: begin
					if (is_wide_reg || sub_reg == 2'h3) begin
						// Wide takes all eight lines at once.
						page_buf[col_reg] <= is_wide_reg ? io_s2 :
							{data_sh_reg, io_s2[4], io_s2[0]};
						loaded_reg[col_reg] <= 1'b1;
						col_reg <= (col_reg + PW'(1)) & page_mask;
						if (got_reg != 2'h2)
							got_reg <= got_reg + 2'h1;
						sub_reg <= 2'h0;
					end else begin
						data_sh_reg <= {data_sh_reg[3:0], io_s2[4], io_s2[0]};
						sub_reg <= sub_reg + 2'h1;
					end
				end
				default: begin
				end
				endcase
			end
		end
	end

	// New contents of the unit under the engine: flash only clears bits.
	assign ubase = page_base_reg[AW-1:0] + AW'({unit_idx_reg, 4'h0});

	always_comb begin
		unit_new = 128'h0;
		unit_touched = is_wide_reg;
		for (int b = 0; b < `UNIT_BYTES; b++) begin
			unit_new[8*b +: 8] = mem[ubase + AW'(b)];
			if (loaded_reg[{unit_idx_reg, 4'(b)}]) begin
				unit_new[8*b +: 8] = mem[ubase + AW'(b)] &
					page_buf[{unit_idx_reg, 4'(b)}];
				unit_touched = 1'b1;
			end
		end
	end

	// Program engine, sector erase and the hidden code storage.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prog_state_reg <= P_IDLE;
			unit_idx_reg <= '0;
			wait_cnt_reg <= 4'h0;
			write_in_progress_reg <= 1'b0;
			write_enable_latch_reg <= 1'b0;
			program_error_reg <= 1'b0;
			for (int i = 0; i < ARRAY_BYTES; i++)
				mem[i] <= `ERASED_BYTE;
			for (int u = 0; u < UNITS; u++)
				meta[u] <= '{1'b0, 1'b0, 8'hFF};
		end else begin
			if (error_clr_reg)
				program_error_reg <= 1'b0;
			case (prog_state_reg)
			P_IDLE: begin
				if (commit_reg) begin
					write_enable_latch_reg <= 1'b0;
					unit_idx_reg <= page_base_reg[PW-1:4];
					if (page_base_reg >= 32'(ARRAY_BYTES)) begin
						program_error_reg <= 1'b1;
					end else begin
						unit_idx_reg <= '0;
						write_in_progress_reg <= 1'b1;
						prog_state_reg <= P_UNIT;
					end
				end else if (erase_req_reg) begin
					// The one-time region has no erase, so it never re-enables.
					for (int j = 0; j < SECTOR_BYTES; j++) begin
						if (int'(erase_sector_reg) * SECTOR_BYTES + j < OTP_BASE)
							mem[int'(erase_sector_reg) * SECTOR_BYTES + j] <=
								`ERASED_BYTE;
					end
					for (int u = 0; u < SECTOR_BYTES / `UNIT_BYTES; u++) begin
						if ((int'(erase_sector_reg) * SECTOR_BYTES +
							u * `UNIT_BYTES) < OTP_BASE)
							meta[int'(erase_sector_reg) *
								(SECTOR_BYTES / `UNIT_BYTES) + u] <=
								'{1'b0, 1'b0, 8'hFF};
					end
				end
			end
			P_UNIT: begin
				for (int b = 0; b < `UNIT_BYTES; b++)
					mem[ubase + AW'(b)] <= unit_new[8*b +: 8];
				if (unit_touched) begin
					if (meta[ubase[AW-1:4]].programmed)
						meta[ubase[AW-1:4]].disabled <= 1'b1;
					else begin
						meta[ubase[AW-1:4]].check <= ecc_code(unit_new);
						meta[ubase[AW-1:4]].programmed <= 1'b1;
					end
				end
				wait_cnt_reg <= PROG_WAIT;
				prog_state_reg <= P_WAIT;
			end
			P_WAIT: begin
				if (wait_cnt_reg != 4'h0)
					wait_cnt_reg <= wait_cnt_reg - 4'h1;
				else if (unit_idx_reg == page_mask[PW-1:4]) begin
					write_in_progress_reg <= 1'b0;
					prog_state_reg <= P_IDLE;
				end else begin
					unit_idx_reg <= unit_idx_reg + IW'(1);
					prog_state_reg <= P_UNIT;
				end
			end
			default: prog_state_reg <= P_IDLE;
			endcase
			// A write enable decoded in the same cycle still lands.
			if (latch_set_reg)
				write_enable_latch_reg <= 1'b1;
		end
	end

	// Corrected read path for the unit under the read pointer.
	always_comb begin
		rd_raw = 128'h0;
		for (int b = 0; b < `UNIT_BYTES; b++)
			rd_raw[8*b +: 8] = mem[{rd_addr_reg[AW-1:4], 4'(b)}];
		rd_meta = meta[rd_addr_reg[AW-1:4]];
		rd_enabled = rd_meta.programmed & ~rd_meta.disabled;
		rd_syn = rd_meta.check ^ ecc_code(rd_raw);
		rd_fixed = rd_enabled ? ecc_fix(rd_raw, rd_syn) : rd_raw;
	end

	// Read mux; unmapped offsets read as zero.
	always_comb begin
		rd_word = 32'h0000_0000;
		if (adr_i == `OFS_CONFIG)
			rd_word = {29'h0, cfg_reg};
		else if (adr_i == `OFS_STATUS) begin
			rd_word[`BIT_BUSY] = write_in_progress_reg;
			rd_word[`BIT_LATCH] = write_enable_latch_reg;
			rd_word[`BIT_PROG_ERROR] = program_error_reg;
		end else if (adr_i == `OFS_ERASE)
			rd_word = {24'h0, erase_sector_reg};
		else if (adr_i == `OFS_READ_ADDR)
			rd_word = 32'(rd_addr_reg);
		else if (adr_i == `OFS_READ_DATA)
			rd_word = rd_fixed[32*rd_addr_reg[3:2] +: 32];
		else if (adr_i == `OFS_UNIT_STATUS)
			rd_word = {29'h0, rd_enabled && rd_syn != 8'h00,
				rd_meta.disabled, rd_meta.programmed};
	end

	// Wishbone slave: acknowledges one cycle after the request is seen.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
			cfg_reg <= `CONFIG_RESET;
			rd_addr_reg <= '0;
			erase_req_reg <= 1'b0;
			erase_sector_reg <= 8'h00;
			error_clr_reg <= 1'b0;
		end else begin
			ack_reg <= cyc_i & stb_i & ~ack_reg;
			erase_req_reg <= 1'b0;
			error_clr_reg <= 1'b0;
			if (cyc_i && stb_i && !ack_reg) begin
				dat_reg <= rd_word;
				if (we_i) begin
					if (adr_i == `OFS_CONFIG)
						cfg_reg <= cfg_merged[2:0];
					else if (adr_i == `OFS_STATUS)
						error_clr_reg <= sel_i[0] & dat_i[`BIT_PROG_ERROR];
					else if (adr_i == `OFS_ERASE && sel_i[0] &&
						!write_in_progress_reg) begin
						erase_req_reg <= 1'b1;
						erase_sector_reg <= dat_i[7:0];
					end else if (adr_i == `OFS_READ_ADDR)
						rd_addr_reg <= rd_addr_merged[AW-1:0];
				end
			end
		end
	end

endmodule

//--- hw/flash_page_program_ecc_defines.svh
// Offsets, field positions, reset values, opcodes and timing counts.
// Assumes inclusion by bare name; definitions only.
`ifndef FLASH_PAGE_PROGRAM_ECC_DEFINES_SVH
`define FLASH_PAGE_PROGRAM_ECC_DEFINES_SVH

// Register byte offsets on the bus.
`define OFS_CONFIG      8'h00
`define OFS_STATUS      8'h04
`define OFS_ERASE       8'h08
`define OFS_READ_ADDR   8'h0C
`define OFS_READ_DATA   8'h10
`define OFS_UNIT_STATUS 8'h14

// Status register one fields.
`define BIT_BUSY        0
`define BIT_LATCH       1
`define BIT_PROG_ERROR  6

// Configuration fields and reset value.
`define BIT_EXT_ADDR    0
`define BIT_WIDE_IO     1
`define BIT_PAGE_LARGE  2
`define CONFIG_RESET    3'h0

// Serial opcodes.
`define OP_WRITE_ENABLE 8'h06
`define OP_PROG         8'h02
`define OP_PROG_ADDR32  8'h12
`define OP_WIDE         8'h32
`define OP_WIDE_ALT     8'h38
`define OP_WIDE_ADDR32  8'h34

// Geometry.
`define UNIT_BYTES      16
`define CHECK_BITS      8
`define PAGE_SMALL      512
`define PAGE_LARGE      1024
`define ERASED_BYTE     8'hFF

// Array time per correction unit, rounded up to clock cycles.
`define CLK_PERIOD_NS   10
`define PROG_UNIT_NS    100
`define PROG_UNIT_CYCLES ((`PROG_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- hw/flash_page_program_ecc_pkg.sv
// Types shared by the program sequencer.
// Assumes the defines header sits beside it.
`include "flash_page_program_ecc_defines.svh"

package flash_page_program_ecc_pkg;

	// Configuration bits as software sees them.
	typedef struct packed {
		logic page_large;
		logic wide_io_enable;
		logic extended_address_flag;
	} config_type;

	// Hidden storage kept beside each 16-byte unit.
	typedef struct packed {
		logic                   programmed;
		logic                   disabled;
		logic [`CHECK_BITS-1:0] check;
	} unit_meta_type;

	typedef enum logic [4:0] {
		S_IDLE   = 5'b00001,
		S_OPCODE = 5'b00010,
		S_ADDR   = 5'b00100,
		S_DATA   = 5'b01000,
		S_IGNORE = 5'b10000
	} spi_state_type;

	typedef enum logic [2:0] {
		P_IDLE = 3'b001,
		P_UNIT = 3'b010,
		P_WAIT = 3'b100
	} prog_state_type;

endpackage

//--- tb/flash_host_model.sv
// Serial host model that drives select, clock and data into the sequencer.
// Assumes each task is entered just after a rising edge of clk_i.
`timescale 1ns/1ps
`include "flash_page_program_ecc_defines.svh"
module flash_host_model (
	input  wire logic       clk_i,
	output logic            cs_n_o,
	output logic            sck_o,
	output logic [7:0]      io_o
);
	// Start idle: select high and the clock parked low.
	initial begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		io_o = 8'h00;
	end

	// Released lines flip each cycle so a stale level never reads as data.
	always @(posedge clk_i) begin
		if (cs_n_o) begin
			io_o <= ~io_o;
		end
	end

	// Three system cycles per phase keep the design's pin sampler happy.
	task automatic half();
		repeat (3) @(posedge clk_i);
	endtask

	// One serial clock; data is set up a whole phase before the rise.
	task automatic tick(input logic [7:0] v);
		io_o <= v;
		half();
		sck_o <= 1'b1;
		half();
		sck_o <= 1'b0;
	endtask

	// Opcode and address go out on the lowest line, MSB first.
	task automatic bits(input logic [31:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			tick({7'h00, v[i]});
		end
	endtask

	// Write enable frame: eight clocks and nothing more.
	task automatic write_enable_cmd();
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		half();
		bits({24'h0, `OP_WRITE_ENABLE}, 8);
		half();
		cs_n_o <= 1'b1;
	endtask

	// Program frame; cut adds a stray clock so a non-wide last byte is partial.
	task automatic prog(input logic [7:0] op, input logic [31:0] a,
		input int na, input int n, input logic [7:0] d0, input logic cut);
		logic [7:0] b;
		logic       wide;
		wide = op inside {`OP_WIDE, `OP_WIDE_ALT, `OP_WIDE_ADDR32};
		@(posedge clk_i);
		cs_n_o <= 1'b0;
		half();
		bits({24'h0, op}, 8);
		bits(a, na * 8);
		for (int k = 0; k < n; k++) begin
			b = d0 + 8'(k);
			if (wide) begin
				tick(b);
			end else begin
				for (int j = 3; j >= 0; j--) begin
					tick({3'h0, b[2*j+1], 3'h0, b[2*j]});
				end
			end
		end
		if (cut) begin
			tick(8'h00);
		end
		half();
		cs_n_o <= 1'b1;
	endtask
endmodule

//--- tb/flash_page_program_ecc_chk.sv
// Bus and status checker for the page program sequencer.
// Assumes it is bound onto the sequencer top and sees its ports only.
`timescale 1ns/1ps
`include "flash_page_program_ecc_defines.svh"
module flash_page_program_ecc_chk (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cs_n_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	logic       st_rd;
	logic       st_wr;
	logic       quiet;
	logic [3:0] hi_cnt;
	logic [2:0] last;
	logic [2:0] cfg;

	// Status accesses as seen at the acknowledging edge.
	assign st_rd = ack_o && !we_i && adr_i == `OFS_STATUS;
	assign st_wr = ack_o && we_i && adr_i == `OFS_STATUS;

	// Cycles since select rose; a commit lands a few cycles late.
	always_ff @(posedge clk_i) begin
		if (rst_i || !cs_n_i) begin
			hi_cnt <= 4'h0;
		end else if (hi_cnt != 4'hF) begin
			hi_cnt <= hi_cnt + 4'h1;
		end
	end

	// Quiet means no frame and no status write since the last read.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			quiet <= 1'b1;
		end else if (hi_cnt != 4'hF || st_wr) begin
			quiet <= 1'b0;
		end else if (st_rd) begin
			quiet <= 1'b1;
		end
	end

	// Status bits from the last read, to compare with the next.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			last <= 3'h0;
		end else if (st_rd) begin
			last <= {dat_o[6], dat_o[1], dat_o[0]};
		end
	end

	// Shadow of the configuration word, written through lane zero.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg <= `CONFIG_RESET;
		end else if (ack_o && we_i && adr_i == `OFS_CONFIG && sel_i[0]) begin
			cfg <= dat_i[2:0];
		end
	end

	property p_ack_pulse; ack_o |=> !ack_o; endproperty
	property p_ack_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
	property p_ack_answer; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
	property p_dat_hold; !(cyc_i && stb_i) |=> $stable(dat_o); endproperty
	property p_unmapped;
		ack_o && !we_i && !(adr_i inside {8'h00, 8'h04, 8'h08, 8'h0C,
			8'h10, 8'h14}) |-> dat_o == 32'h0;
	endproperty
	property p_cfg;
		ack_o && !we_i && adr_i == `OFS_CONFIG |-> dat_o[2:0] == cfg;
	endproperty
	property p_busy; st_rd && quiet && !last[0] |-> !dat_o[0]; endproperty
	property p_latch; st_rd && quiet && !last[1] |-> !dat_o[1]; endproperty
	property p_err; st_rd && quiet && !last[2] |-> !dat_o[6]; endproperty

	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
	a_ack_answer: assert property (p_ack_answer) else $error("no ack");
	a_dat_hold: assert property (p_dat_hold) else $error("data moved");
	a_unmapped: assert property (p_unmapped) else $error("hole data");
	a_cfg: assert property (p_cfg) else $error("config");
	a_busy: assert property (p_busy) else $error("busy");
	a_latch: assert property (p_latch) else $error("latch");
	a_err: assert property (p_err) else $error("error bit");

	c_busy: cover property (st_rd && dat_o[0]);
	c_err: cover property (st_rd && dat_o[6]);
	c_wide: cover property (ack_o && we_i && adr_i == `OFS_CONFIG && dat_i[1]);
endmodule

bind flash_page_program_ecc flash_page_program_ecc_chk
	flash_page_program_ecc_chk_inst (.clk_i(clk_i), .rst_i(rst_i),
	.cs_n_i(cs_n_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
	.ack_o(ack_o));

//--- tb/flash_page_program_ecc_tb.sv
// Self-checking bench for the page program sequencer.
// Assumes the serial host model and the bound checker are compiled too.
`timescale 1ns/1ps
`include "flash_page_program_ecc_defines.svh"
module flash_page_program_ecc_tb;
	logic        clk_i;
	logic        rst_i;
	logic        cs_n_i;
	logic        sck_i;
	logic [7:0]  io_i;
	logic        cyc_i;
	logic        stb_i;
	logic        we_i;
	logic [7:0]  adr_i;
	logic [3:0]  sel_i;
	logic [31:0] dat_i;
	logic [31:0] dat_o;
	logic        ack_o;
	logic [31:0] rd;
	int          n_errors;
	int          tests_run;
	typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;}
		row_type;
	// Register rows: a read compares with e, a write only stores d.
	row_type rows [8] = '{'{1'b0, 8'h04, 32'h0, 32'h0},
		'{1'b0, 8'h00, 32'h0, 32'h0}, '{1'b1, 8'h00, 32'h7, 32'h0},
		'{1'b0, 8'h00, 32'h0, 32'h7}, '{1'b1, 8'h00, 32'h0, 32'h0},
		'{1'b0, 8'h40, 32'h0, 32'h0}, '{1'b1, 8'h40, 32'h5, 32'h0},
		'{1'b0, 8'h40, 32'h0, 32'h0}};
	logic [7:0]  ops [3] = '{`OP_WIDE, `OP_WIDE_ALT, `OP_WIDE_ADDR32};

	flash_page_program_ecc flash_page_program_ecc_inst (.clk_i(clk_i),
		.rst_i(rst_i), .cs_n_i(cs_n_i), .sck_i(sck_i), .io_i(io_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o));
	flash_host_model flash_host_model_inst (.clk_i(clk_i),
		.cs_n_o(cs_n_i), .sck_o(sck_i), .io_o(io_i));

	// Free-running 100 MHz clock.
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic results();
		$display("mismatches %0d of %0d checks", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask

	// One classic cycle; the wait is bounded so a dead slave ends the run.
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int t;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		sel_i <= 4'hF;
		t = 0;
		do begin
			@(posedge clk_i);
			t++;
		end while (ack_o !== 1'b1 && t < 50);
		if (t >= 50) begin
			n_errors++;
			$display("ERROR %0t bus timeout", $time);
			results();
		end
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask

	// Poll status until the busy bit drops, within a bound.
	task automatic settle();
		int t;
		repeat (8) @(posedge clk_i);
		t = 0;
		do begin
			wb(1'b0, `OFS_STATUS, 32'h0);
			t++;
		end while (rd[0] !== 1'b0 && t < 500);
		if (t >= 500) begin
			n_errors++;
			$display("ERROR %0t busy stuck", $time);
			results();
		end
	endtask

	// Optional enable, one frame, then busy as expected and completion.
	task automatic run(input logic w, input logic [7:0] op,
		input logic [31:0] a, input int na, input int n,
		input logic [7:0] d0, input logic cut, input logic bz);
		if (w) begin
			flash_host_model_inst.write_enable_cmd();
		end
		flash_host_model_inst.prog(op, a, na, n, d0, cut);
		repeat (6) @(posedge clk_i);
		wb(1'b0, `OFS_STATUS, 32'h0);
		chk({31'h0, rd[0]}, {31'h0, bz});
		settle();
	endtask

	// Corrected word and unit state at a byte address.
	task automatic look(input logic [31:0] a, input logic [31:0] d,
		input logic [1:0] u);
		wb(1'b1, `OFS_READ_ADDR, a);
		wb(1'b0, `OFS_READ_DATA, 32'h0);
		chk(rd, d);
		wb(1'b0, `OFS_UNIT_STATUS, 32'h0);
		chk({29'h0, rd[2:0]}, {30'h0, u});
	endtask

	// Reset, register rows, then the program sequences.
	initial begin
		n_errors = 0;
		tests_run = 0;
		rst_i = 1'b1;
		{cyc_i, stb_i, we_i} = 3'h0;
		adr_i = 8'h00;
		sel_i = 4'h0;
		dat_i = 32'h0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (rows[i]) begin
			wb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) chk(rd, rows[i].e);
		end
		flash_host_model_inst.write_enable_cmd();
		repeat (8) @(posedge clk_i);
		wb(1'b0, `OFS_STATUS, 32'h0);
		chk(rd & 32'h43, 32'h2);
		run(1'b1, `OP_PROG, 32'h010, 3, 16, 8'h10, 1'b0, 1'b1);
		look(32'h010, 32'h13121110, 2'b01);
		look(32'h020, 32'hFFFFFFFF, 2'b00);
		run(1'b1, `OP_PROG, 32'h018, 3, 1, 8'h00, 1'b0, 1'b1);
		look(32'h010, 32'h13121110, 2'b11);
		wb(1'b1, `OFS_ERASE, 32'h0);
		look(32'h010, 32'hFFFFFFFF, 2'b00);
		run(1'b0, `OP_PROG, 32'h030, 3, 1, 8'h00, 1'b0, 1'b0);
		look(32'h030, 32'hFFFFFFFF, 2'b00);
		run(1'b1, `OP_PROG, 32'h1FE, 3, 4, 8'hA0, 1'b0, 1'b1);
		look(32'h000, 32'hFFFFA3A2, 2'b01);
		look(32'h1FC, 32'hA1A0FFFF, 2'b01);
		run(1'b1, `OP_PROG, 32'h200, 3, 2, 8'h00, 1'b1, 1'b0);
		look(32'h200, 32'hFFFFFFFF, 2'b00);
		run(1'b1, `OP_PROG_ADDR32, 32'h040, 4, 1, 8'h44, 1'b0,
			1'b1);
		look(32'h040, 32'hFFFFFF44, 2'b01);
		run(1'b1, `OP_WIDE, 32'h400, 3, 2, 8'h55, 1'b0, 1'b0);
		wb(1'b1, `OFS_CONFIG, 32'h2);
		// One wide program per erased page; 34h always takes 4 bytes.
		for (int i = 0; i < 3; i++) begin
			run(1'b1, ops[i], 32'h400 + 32'(i) * 32'h200,
				(i == 2) ? 4 : 3, 2, 8'h55, 1'b0, 1'b1);
			look(32'h400 + 32'(i) * 32'h200, 32'hFFFF5655, 2'b01);
			look(32'h5F0 + 32'(i) * 32'h200, 32'hFFFFFFFF, 2'b01);
		end
		wb(1'b1, `OFS_CONFIG, 32'h3);
		run(1'b1, `OP_PROG, 32'hA00, 4, 1, 8'h77, 1'b0, 1'b1);
		look(32'hA00, 32'hFFFFFF77, 2'b01);
		run(1'b0, `OP_WIDE_ADDR32, 32'h240, 4, 2, 8'h00, 1'b0, 1'b0);
		look(32'h240, 32'hFFFFFFFF, 2'b00);
		run(1'b1, `OP_PROG, 32'hC00, 4, 1, 8'h11, 1'b0, 1'b1);
		run(1'b1, `OP_PROG, 32'hC01, 4, 1, 8'h22, 1'b0, 1'b1);
		wb(1'b1, `OFS_ERASE, 32'h3);
		look(32'hC00, 32'hFFFF2211, 2'b11);
		// A 1024-byte page wraps at its own boundary, not at 512.
		wb(1'b1, `OFS_CONFIG, 32'h7);
		wb(1'b1, `OFS_ERASE, 32'h1);
		run(1'b1, `OP_PROG, 32'h7FE, 4, 4, 8'hB0, 1'b0, 1'b1);
		look(32'h400, 32'hFFFFB3B2, 2'b01);
		look(32'h7FC, 32'hB1B0FFFF, 2'b01);
		flash_host_model_inst.write_enable_cmd();
		flash_host_model_inst.prog(`OP_PROG, 32'h1000, 4, 1, 8'h00,
			1'b0);
		settle();
		chk(rd & 32'h40, 32'h40);
		wb(1'b1, `OFS_STATUS, 32'h40);
		wb(1'b0, `OFS_STATUS, 32'h0);
		chk(rd & 32'h43, 32'h0);
		// A reset in mid-run brings back the power-on state.
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, `OFS_CONFIG, 32'h0);
		chk(rd, 32'h0);
		look(32'h400, 32'hFFFFFFFF, 2'b00);
		results();
	end
endmodule
